// ### hw/spi_timing_pkg.sv
package spi_timing_pkg;

    // ----------------------------------------------------------------
    // control field positions
    // ----------------------------------------------------------------
    localparam int CTRL_W = 8;
    localparam int DIV_W = 7;
    localparam int MASTER_SEL_POS = 2;
    localparam int CLOCK_PHASE_POS = 3;
    localparam int CLOCK_POL_POS = 6;

    // ----------------------------------------------------------------
    // bit-clock period figures, in peripheral-clock cycles
    // ----------------------------------------------------------------
    localparam logic [6:0] MIN_DIVISOR = 7'h04;
    localparam logic [6:0] MIN_PERIOD_M1 = 7'h03;
    localparam logic [7:0] MIN_PERIOD = 8'h04;
    localparam logic [7:0] MAX_PERIOD = 8'h80;
    localparam logic [7:0] MIN_ODD_PERIOD = 8'h05;
    localparam logic [7:0] MAX_ODD_PERIOD = 8'h7f;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [6:0] DIVISOR_RST = 7'h00;
    localparam logic SLAVE_SELECT_RST = 1'b1;
    localparam logic BIT_CLOCK_RST = 1'b0;
    localparam logic [7:0] HELPER_RST = 8'h00;

    // ----------------------------------------------------------------
    // word framing states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LEAD = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_TRAIL = 4'b1000
    } state_type;

    // period minus one for a divisor field value
    function automatic logic [6:0] period_m1(input logic [6:0] div);
        period_m1 = (div < MIN_DIVISOR) ? MIN_PERIOD_M1 : div;
    endfunction : period_m1

    // length of the first (active) half, rounded down
    function automatic logic [6:0] half_lo(input logic [6:0] pm1);
        logic [7:0] p;
        p = {1'b0, pm1} + 8'h01;
        half_lo = p[7:1];
    endfunction : half_lo

endpackage : spi_timing_pkg

// ### hw/two_stage_sync.sv
`timescale 1ns/1ns
`default_nettype none

module two_stage_sync
    import spi_timing_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic async_i,
    output logic sync_o
);

    logic stage1;
    logic stage2;

    // ----------------------------------------------------------------
    // two flops, the first read only by the second
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;

endmodule : two_stage_sync

`default_nettype wire

// ### hw/bit_period_timer.sv
`timescale 1ns/1ns
`default_nettype none

module bit_period_timer
    import spi_timing_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic run_i,
    input wire logic [DIV_W-1:0] period_m1_i,
    input wire logic [DIV_W-1:0] half_lo_i,
    output logic start_o,
    output logic mid_o
);

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic next_start;
    logic next_mid;

    // ----------------------------------------------------------------
    // counter preloads to the mid point so the first start is half away
    // ----------------------------------------------------------------
    always_comb begin
        if (!run_i) begin
            next_cnt = half_lo_i;
        end else if (cnt == period_m1_i) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + 7'h01;
        end
        next_start = run_i && (next_cnt == '0);
        next_mid = run_i && (next_cnt == half_lo_i);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt <= DIVISOR_RST;
            start_o <= 1'b0;
            mid_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            start_o <= next_start;
            mid_o <= next_mid;
        end
    end

endmodule : bit_period_timer

`default_nettype wire

// ### hw/spi_master_phase0_timing.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - bit period is four cycles for divisor below four, else divisor plus one
// - period spans 4..128 cycles, or 5..127 for even divisors above three
// - odd period: active half half a cycle short, idle half longer
// - works only with master bit 2 set and phase bit 3 clear
// - polarity bit 6 picks active edge, swapping launch and sample edges
// - idle-low: data changes after rising edge, sampled on falling edge
// - idle-high: data changes after falling edge, sampled on rising edge
// - slave select goes low at least half a period before first edge
// - slave select rises one idle half (period minus active half) after the last sampling edge
// - back-to-back words keep slave select low between them
module spi_master_phase0_timing
    import spi_timing_pkg::*;
#(
    parameter int WORD_W = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [CTRL_W-1:0] operation_control_reg_i,
    input wire logic [CTRL_W-1:0] config_control_reg_i,
    input wire logic [DIV_W-1:0] baud_divisor_field_i,
    input wire logic tx_valid_i,
    input wire logic [WORD_W-1:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [WORD_W-1:0] rx_data_o,
    output logic busy_o,
    output logic serial_bit_clock_o,
    output logic master_out_line_o,
    input wire logic master_in_line_i,
    output logic slave_select_n_o
);

    localparam int BW = (WORD_W > 1) ? $clog2(WORD_W) : 1;
    localparam logic [BW-1:0] LAST_BIT = BW'(WORD_W - 1);

    state_type state, next_state;
    logic [DIV_W-1:0] div_q, next_div;
    logic pol_q, next_pol;
    logic [WORD_W-1:0] sh, next_sh;
    logic [BW-1:0] bit_cnt, next_bit_cnt;
    logic pending, next_pending;
    logic next_sclk, next_mosi, next_ss_n, next_tx_ready, next_rx_valid;
    logic [WORD_W-1:0] next_rx_data;
    logic [DIV_W-1:0] pm1, lo;
    logic start_p, mid_p, miso_s, enabled, pol_live, accept;

    // ----------------------------------------------------------------
    // control decode
    // ----------------------------------------------------------------
    assign enabled = operation_control_reg_i[MASTER_SEL_POS]
                     && !operation_control_reg_i[CLOCK_PHASE_POS];
    assign pol_live = config_control_reg_i[CLOCK_POL_POS];
    assign pm1 = period_m1(div_q);
    assign lo = half_lo(pm1);
    assign accept = tx_valid_i && tx_ready_o;

    // ----------------------------------------------------------------
    // incoming data line and period timer
    // ----------------------------------------------------------------
    two_stage_sync u_miso_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(master_in_line_i),
        .sync_o(miso_s)
    );

    bit_period_timer u_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(state != ST_IDLE),
        .period_m1_i(pm1),
        .half_lo_i(lo),
        .start_o(start_p),
        .mid_o(mid_p)
    );

    // ----------------------------------------------------------------
    // framing next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_div = div_q;
        next_pol = pol_q;
        next_sh = sh;
        next_bit_cnt = bit_cnt;
        next_pending = pending;
        next_sclk = serial_bit_clock_o;
        next_mosi = master_out_line_o;
        next_ss_n = slave_select_n_o;
        next_rx_valid = 1'b0;
        next_rx_data = rx_data_o;
        unique case (state)
            ST_IDLE: begin
                next_sclk = pol_live;
                next_pol = pol_live;
                next_div = baud_divisor_field_i;
                if (accept) begin
                    next_sh = tx_data_i;
                    next_bit_cnt = '0;
                    next_ss_n = 1'b0;
                    next_state = ST_LEAD;
                end
            end
            ST_LEAD: begin
                // first edge comes more than half a period after select
                if (start_p) begin
                    next_sclk = ~pol_q;
                    next_mosi = sh[WORD_W-1];
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (start_p) begin
                    next_sclk = ~pol_q;
                    next_mosi = sh[WORD_W-1];
                end
                if (mid_p) begin
                    next_sclk = pol_q;
                    next_sh = {sh[WORD_W-2:0], miso_s};
                    if (bit_cnt == LAST_BIT) begin
                        next_rx_valid = 1'b1;
                        next_rx_data = {sh[WORD_W-2:0], miso_s};
                        next_state = ST_TRAIL;
                    end else begin
                        next_bit_cnt = bit_cnt + 1'b1;
                    end
                end
            end
            ST_TRAIL: begin
                if (accept) begin
                    next_sh = tx_data_i;
                    next_pending = 1'b1;
                end
                if (start_p) begin
                    if (pending || accept) begin
                        // next word follows without releasing select
                        next_sclk = ~pol_q;
                        next_mosi = accept ? tx_data_i[WORD_W-1] : sh[WORD_W-1];
                        next_pending = 1'b0;
                        next_bit_cnt = '0;
                        next_state = ST_SHIFT;
                    end else begin
                        next_ss_n = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_ss_n = 1'b1;
            end
        endcase
        next_tx_ready = enabled && ((next_state == ST_IDLE)
                        || (next_state == ST_TRAIL && !next_pending));
    end

    // ----------------------------------------------------------------
    // framing registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
            div_q <= DIVISOR_RST;
            pol_q <= BIT_CLOCK_RST;
            sh <= '0;
            bit_cnt <= '0;
            pending <= 1'b0;
            serial_bit_clock_o <= BIT_CLOCK_RST;
            master_out_line_o <= 1'b0;
            slave_select_n_o <= SLAVE_SELECT_RST;
            tx_ready_o <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= '0;
            busy_o <= 1'b0;
        end else begin
            state <= next_state;
            div_q <= next_div;
            pol_q <= next_pol;
            sh <= next_sh;
            bit_cnt <= next_bit_cnt;
            pending <= next_pending;
            serial_bit_clock_o <= next_sclk;
            master_out_line_o <= next_mosi;
            slave_select_n_o <= next_ss_n;
            tx_ready_o <= next_tx_ready;
            rx_valid_o <= next_rx_valid;
            rx_data_o <= next_rx_data;
            busy_o <= !next_ss_n;
        end
    end

    // ----------------------------------------------------------------
    // checking helpers: edge spacing and half lengths
    // ----------------------------------------------------------------
    logic [7:0] edge_gap, act_len, idle_len, period_full, hi_len;
    logic seen_fall, sclk_active, fall_edge;

    assign sclk_active = (serial_bit_clock_o != pol_q);
    assign fall_edge = !slave_select_n_o && !sclk_active
                       && (act_len != 8'h00) && (state != ST_IDLE);
    assign period_full = {1'b0, pm1} + 8'h01;
    assign hi_len = period_full - {1'b0, lo};

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            edge_gap <= HELPER_RST;
            act_len <= HELPER_RST;
            idle_len <= HELPER_RST;
            seen_fall <= 1'b0;
        end else begin
            act_len <= sclk_active ? act_len + 8'h01 : 8'h00;
            idle_len <= (slave_select_n_o || sclk_active) ? 8'h00 : idle_len + 8'h01;
            edge_gap <= (fall_edge || slave_select_n_o) ? 8'h00 : edge_gap + 8'h01;
            seen_fall <= slave_select_n_o ? 1'b0 : (seen_fall || fall_edge);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_period;
        fall_edge && seen_fall |-> edge_gap == {1'b0, pm1};
    endproperty
    a_period: assert property (p_period) else $error("bit period wrong");

    property p_range;
        !slave_select_n_o |-> (period_full[0] == 1'b0 || pm1 == MIN_PERIOD_M1)
            ? (period_full >= MIN_PERIOD && period_full <= MAX_PERIOD)
            : (period_full >= MIN_ODD_PERIOD && period_full <= MAX_ODD_PERIOD);
    endproperty
    a_range: assert property (p_range) else $error("period out of range");

    property p_halves;
        fall_edge |-> act_len == {1'b0, lo};
    endproperty
    a_halves: assert property (p_halves) else $error("active half length wrong");

    property p_disabled;
        slave_select_n_o && !enabled && !tx_ready_o |=> slave_select_n_o;
    endproperty
    a_disabled: assert property (p_disabled) else $error("started while not enabled");

    property p_launch_low;
        !pol_q && !slave_select_n_o && $changed(master_out_line_o)
            |-> serial_bit_clock_o && !$past(serial_bit_clock_o);
    endproperty
    a_launch_low: assert property (p_launch_low) else $error("data moved off rising edge");

    property p_launch_high;
        pol_q && !slave_select_n_o && $changed(master_out_line_o)
            |-> !serial_bit_clock_o && $past(serial_bit_clock_o);
    endproperty
    a_launch_high: assert property (p_launch_high) else $error("data moved off falling edge");

    property p_polarity;
        rx_valid_o |-> serial_bit_clock_o == pol_q && $past(serial_bit_clock_o) != pol_q;
    endproperty
    a_polarity: assert property (p_polarity) else $error("sample edge not polarity edge");

    property p_lead;
        $fell(slave_select_n_o) |-> !sclk_active [*2];
    endproperty
    a_lead: assert property (p_lead) else $error("select lead too short");

    // select-to-first-edge span, counted by the edge gap helper
    property p_lead_span;
        state == ST_LEAD && start_p |-> edge_gap >= {1'b0, lo};
    endproperty
    a_lead_span: assert property (p_lead_span) else $error("select lead under half period");

    property p_trail;
        $rose(slave_select_n_o) |-> idle_len == hi_len;
    endproperty
    a_trail: assert property (p_trail) else $error("select release not half period");

    property p_back_to_back;
        state == ST_TRAIL && start_p && (pending || accept) |=> !slave_select_n_o [*2];
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("select dropped between words");

    property p_idle_level;
        slave_select_n_o && $past(slave_select_n_o) && $stable(pol_live)
            |=> serial_bit_clock_o == $past(pol_live);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("bit clock not at idle level");

    c_word: cover property ($rose(slave_select_n_o));
    c_back_to_back: cover property (state == ST_TRAIL && start_p && pending);
    c_odd_period: cover property (fall_edge && period_full[0]);
    c_idle_high: cover property (pol_q && rx_valid_o);

endmodule : spi_master_phase0_timing

`default_nettype wire

// ### verification/spi_slave_model.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// phase-zero slave: first bit at select, next after each sample
// ------------------------------------------------------------
module spi_slave_model (
    input wire logic clk_i,
    input wire logic pol_i,
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic [7:0] reply_i,
    output logic miso_o,
    output logic [7:0] got_o
);
    int cnt = 0;
    logic [7:0] sh = 8'h00;
    logic sclk_d = 1'b0;
    logic ss_d = 1'b1;
    logic miso_q = 1'b0;
    logic [7:0] got_q = 8'h00;

    assign miso_o = miso_q;
    assign got_o = got_q;

    // one process: select, capture on the idle-going edge, offer next bit
    always @(posedge clk_i) begin
        if (ss_n_i) begin
            // deselected line keeps changing so stale data never matches
            cnt = 0;
            miso_q <= ~miso_q;
        end else if (ss_d) begin
            miso_q <= reply_i[7];
        end else if (sclk_i != sclk_d && sclk_i == pol_i) begin
            sh = {sh[6:0], mosi_i};
            cnt = (cnt + 1) % 8;
            if (cnt == 0) got_q <= sh;
            miso_q <= reply_i[7 - cnt];
        end
        sclk_d <= sclk_i;
        ss_d <= ss_n_i;
    end
endmodule : spi_slave_model

`default_nettype wire

// ### verification/spi_master_phase0_timing_tb.sv
`timescale 1ns/1ns
`default_nettype none

module spi_master_phase0_timing_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] op = 8'h04;
    logic [7:0] cfg = 8'h00;
    logic [6:0] divisor = 7'h00;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] reply = 8'h00;
    logic tx_ready, rx_valid, busy, sclk, mosi, miso, ss_n;
    logic [7:0] rx_data, got;
    int n_fail = 0;
    int n_compared = 0;

    // clock at 25 MHz
    always #20 clk = ~clk;

    spi_master_phase0_timing #(.WORD_W(8)) DUT (
        .clk_i(clk), .reset_i(reset), .operation_control_reg_i(op),
        .config_control_reg_i(cfg), .baud_divisor_field_i(divisor),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .busy_o(busy),
        .serial_bit_clock_o(sclk), .master_out_line_o(mosi),
        .master_in_line_i(miso), .slave_select_n_o(ss_n)
    );

    spi_slave_model slave (
        .clk_i(clk), .pol_i(cfg[6]), .sclk_i(sclk), .ss_n_i(ss_n),
        .mosi_i(mosi), .reply_i(reply), .miso_o(miso), .got_o(got)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : cmp

    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // set mode bits, let the idle level settle, check it
    task automatic setup(input logic [7:0] o, input logic pol, input logic [6:0] div);
        @(posedge clk);
        op <= o;
        cfg <= {1'b0, pol, 6'h00};
        divisor <= div;
        repeat (3) @(posedge clk);
        #1;
        cmp(sclk, pol, "idle clock level");
        cmp(ss_n, 1'b1, "idle select");
    endtask : setup

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // one burst of nw words, every edge timed and every bit checked
    task automatic run_word(input logic [6:0] div, input logic pol, input logic [7:0] d0,
            input logic [7:0] d1, input int nw);
        int p, lo, cyc, t_ss, t_last, t_end, edges, nt, nrx;
        logic pc, ps, take, fin, prx;
        logic [15:0] bits;
        p = (div < 4) ? 4 : div + 1;
        lo = p / 2;
        cyc = 0; t_ss = 0; t_last = 0; t_end = 0; edges = 0; nt = 0; nrx = 0;
        take = 0; fin = 0; prx = 0;
        bits = {d0, d1};
        setup(8'h04, pol, div);
        pc = sclk;
        ps = ss_n;
        @(posedge clk);
        tx_data <= d0;
        reply <= ~d0;
        tx_valid <= 1'b1;
        // take flags the edge ahead, from values that stand before it
        #1;
        take = tx_ready === 1'b1;
        while (!fin && cyc < 2500) begin
            @(posedge clk);
            if (take) begin
                nt++;
                if (nt < nw) tx_data <= d1;
                else tx_valid <= 1'b0;
            end
            #1;
            cyc++;
            take = tx_valid && tx_ready === 1'b1;
            cmp(busy, !ss_n, "busy follows select");
            if (ps && !ss_n) t_ss = cyc;
            if (sclk !== pc && sclk !== pol) begin
                if (edges == 0) cmp(2 * (cyc - t_ss) >= p, 1, "select lead");
                else cmp(cyc - t_last, p - lo, "idle half");
                cmp(mosi, bits[15 - edges], "data out");
                t_last = cyc;
                edges++;
            end else if (sclk !== pc) begin
                cmp(cyc - t_last, lo, "active half");
                t_last = cyc;
                t_end = cyc;
            end
            // slave word lands one clock after the receive pulse
            if (prx) cmp(got, nrx > 1 ? d1 : d0, "slave word");
            prx = rx_valid === 1'b1;
            if (prx) begin
                cmp(rx_data, d0 ^ 8'hff, "received word");
                nrx++;
            end
            if (!ps && ss_n) begin
                fin = 1;
                cmp(edges, 8 * nw, "edges in burst");
                cmp(cyc - t_end, p - lo, "select trail");
                cmp(sclk, pol, "clock idle after burst");
            end
            pc = sclk;
            ps = ss_n;
        end
        cmp(fin, 1, "burst ended");
        cmp(nrx, nw, "received count");
        $display("burst test div %0d pol %0d words %0d done", div, pol, nw);
    endtask : run_word

    // word offered while master clear or phase set is never taken
    task automatic refuse_test;
        logic [7:0] modes [3] = '{8'h0c, 8'h00, 8'h08};
        foreach (modes[i]) begin
            setup(modes[i], 1'b0, 7'h04);
            @(posedge clk);
            tx_valid <= 1'b1;
            repeat (12) begin
                @(posedge clk);
                #1;
                cmp(tx_ready, 1'b0, "ready while disabled");
                cmp(ss_n, 1'b1, "select while disabled");
            end
            @(posedge clk);
            tx_valid <= 1'b0;
        end
        $display("refuse test done");
    endtask : refuse_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    // periods 4 to 128 cycles, at most 6.25 MHz, within link limits
    logic [6:0] divs [8] = '{7'h00, 7'h02, 7'h03, 7'h04, 7'h05, 7'h08, 7'h7e, 7'h7f};
    initial begin
        repeat (7) @(posedge clk);
        #1;
        cmp(ss_n, 1'b1, "select in reset");
        cmp(tx_ready, 1'b0, "ready in reset");
        @(posedge clk);
        reset <= 1'b0;
        foreach (divs[i]) run_word(divs[i], i[0], 8'h96 ^ 8'(i), 8'h00, 1);
        run_word(7'h07, 1'b0, 8'h3c, 8'hc3, 2);
        run_word(7'h04, 1'b1, 8'h81, 8'h7e, 2);
        refuse_test();
        wrap_up();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("ERROR %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : spi_master_phase0_timing_tb

`default_nettype wire
